/* File: bench/ddpd_host_model.sv */
// Host-side serial master model for the power-down block
`timescale 1ns/1ps
module ddpd_host_model (
  input  wire logic clock,
  output logic      frame_n,
  output logic      sclk,
  output logic      din
);
  logic idle_bit;
  logic live_bit;
  initial begin
    frame_n  = 1'b1;
    sclk     = 1'b0;
    idle_bit = 1'b0;
    live_bit = 1'b0;
  end
  // Idle data toggles so a stale bit never passes for a live one
  always @(posedge clock) if (frame_n) idle_bit <= ~idle_bit;
  assign din = frame_n ? idle_bit : live_bit;
  // Word goes out MSB first; a byte host pauses mid-frame
  task automatic send(input logic [15:0] w, input int nbits, input bit bytes);
    frame_n <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      if (bytes && i == 8) repeat (8) @(posedge clock);
      sclk <= 1'b1;
      live_bit <= w[15 - (i % 16)];
      repeat (4) @(posedge clock);
      sclk <= 1'b0;
      repeat (4) @(posedge clock);
    end
    frame_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule // ddpd_host_model

/* File: bench/testbench.sv */
// Self-checking bench for the dual DAC power-down block
`timescale 1ns/1ps
module testbench;
  import ddpd_pkg::*;
  logic                 clock          = 1'b0;
  logic                 srst           = 1'b1;
  logic                 hw_powerdown_n = 1'b1;
  logic                 output_load_n  = 1'b1;
  logic                 low_supply     = 1'b0;
  logic                 frame_n, sclk, din;
  logic [DATA_BITS-1:0] dac_code_a, dac_code_b;
  logic                 gain_a, gain_b, amp_on_a, amp_on_b, out_valid_a, out_valid_b;
  logic [1:0]           term_a, term_b;
  int                   fails = 0;
  int                   comparisons = 0;
  int                   n;
  // Word, then {gain a,b, term a,b} and codes a,b after a load
  logic [45:0] rows [6] = '{
    {16'h0ABC, 6'h00, 24'hAB_C000},
    {16'hD123, 6'h11, 24'hAB_C123},
    {16'h2555, 6'h19, 24'h55_5123},
    {16'hB7FF, 6'h0B, 24'h55_57FF},
    {16'h0FFF, 6'h03, 24'hFF_F7FF},
    {16'hC001, 6'h10, 24'hFF_F001}};
  always #5 clock = ~clock;
  ddpd_host_model host (.clock(clock), .frame_n(frame_n), .sclk(sclk), .din(din));
  ddpd_top #(.EXIT_CYC_HI(8), .EXIT_CYC_LO(16)) dut (
    .clock(clock), .srst(srst), .frame_n(frame_n), .sclk(sclk), .din(din),
    .hw_powerdown_n(hw_powerdown_n), .output_load_n(output_load_n), .low_supply(low_supply),
    .dac_code_a(dac_code_a), .dac_code_b(dac_code_b), .gain_a(gain_a), .gain_b(gain_b),
    .term_a(term_a), .term_b(term_b), .amp_on_a(amp_on_a), .amp_on_b(amp_on_b),
    .out_valid_a(out_valid_a), .out_valid_b(out_valid_b));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Amplifier and valid flag follow the expected termination
  task automatic check_all(input logic [29:0] e);
    logic [1:0] on;
    on = {e[27:26] == 2'h0, e[25:24] == 2'h0};
    chk("outputs", 32'(e), 32'({gain_a, gain_b, term_a, term_b, dac_code_a, dac_code_b}));
    chk("amp_valid", 32'({on, on}), 32'({amp_on_a, amp_on_b, out_valid_a, out_valid_b}));
  endtask
  task automatic load();
    output_load_n <= 1'b0;
    repeat (8) @(posedge clock);
    output_load_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (5) @(posedge clock);
    check_all({6'h00, 24'h00_0000});
    foreach (rows[i]) begin
      host.send(rows[i][45:30], 16, 1'b0);
      load();
      check_all(rows[i][29:0]);
    end
    host.send(16'h4ABC, 10, 1'b0);
    load();
    check_all({6'h10, 24'hFF_F001});
    host.send(16'h0123, 18, 1'b0);
    load();
    check_all({6'h10, 24'h12_3001});
    host.send(16'h8456, 16, 1'b1);
    load();
    check_all({6'h00, 24'h12_3456});
    hw_powerdown_n <= 1'b0;
    repeat (8) @(posedge clock);
    check_all({6'h0F, 24'h12_3456});
    // Bounded wait; a hang falls out of range and counts
    for (int ls = 0; ls < 2; ls++) begin
      low_supply     <= ls[0];
      hw_powerdown_n <= 1'b0;
      repeat (8) @(posedge clock);
      hw_powerdown_n <= 1'b1;
      n = 0;
      while (out_valid_a !== 1'b1 && n < 60) begin
        @(posedge clock);
        n++;
      end
      chk("exit_cycles", 32'h0000_0001, 32'(n >= 8 + 8 * ls && n <= 20 + 8 * ls));
    end
    check_all({6'h00, 24'h12_3456});
    // Mid-run reset must clear codes and gains again
    srst <= 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (5) @(posedge clock);
    check_all({6'h00, 24'h00_0000});
    give_verdict();
  end
endmodule // testbench

/* File: rtl/ddpd_pkg.sv */
// Constants for the dual DAC power-down serial load block
package ddpd_pkg;
  localparam int          WORD_BITS      = 16;
  localparam int          CNT_W          = 5;
  localparam logic [4:0]  FRAME_BITS     = 5'h10;
  localparam int          POS_CHAN       = 15;
  localparam int          POS_GAIN       = 14;
  localparam int          POS_PWRDN_HI   = 13;
  localparam int          POS_PWRDN_LO   = 12;
  localparam int          DATA_BITS      = 12;
  localparam logic [11:0] CODE_RESET     = 12'h000;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          EXIT_NS_5V     = 2500;
  localparam int          EXIT_NS_3V     = 5000;
  localparam int          EXIT_CYC_5V    = EXIT_NS_5V / CLK_PERIOD_NS;
  localparam int          EXIT_CYC_3V    = EXIT_NS_3V / CLK_PERIOD_NS;
  localparam int          EXIT_W         = 13;
  typedef enum logic [1:0] {
    DDPD_MODE_NORMAL = 2'h0,
    DDPD_MODE_1K     = 2'h1,
    DDPD_MODE_100K   = 2'h2,
    DDPD_MODE_HIZ    = 2'h3
  } ddpd_mode_t;
endpackage

/* File: rtl/ddpd_top.sv */
// Dual DAC power-down control with 16-bit serial load
// Overview of operation
// - Mode change affects only the addressed channel
// - Mode select bits are word bits 13,12
// - 00 normal, 01 1k, 10 100k, 11 hi-z
// - Powered-down output switched to chosen termination
// - Registers keep contents during power-down
// - Output valid after 2.5 or 5 us
// - Low power-down pin forces both hi-z
// - Word bit 15 selects channel A/B
// - Shift 16 falling edges, ignore extras
// - Early frame end aborts, nothing changes
// - Reset: normal mode, code, gain and mode registers zero
`timescale 1ns/1ps
module ddpd_top
  import ddpd_pkg::*;
#(
  parameter int EXIT_CYC_HI = EXIT_CYC_5V,
  parameter int EXIT_CYC_LO = EXIT_CYC_3V
) (
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 frame_n,
  input  wire logic                 sclk,
  input  wire logic                 din,
  input  wire logic                 hw_powerdown_n,
  input  wire logic                 output_load_n,
  input  wire logic                 low_supply,
  output logic      [DATA_BITS-1:0] dac_code_a,
  output logic      [DATA_BITS-1:0] dac_code_b,
  output logic                      gain_a,
  output logic                      gain_b,
  output logic      [1:0]           term_a,
  output logic      [1:0]           term_b,
  output logic                      amp_on_a,
  output logic                      amp_on_b,
  output logic                      out_valid_a,
  output logic                      out_valid_b
);

  // Pin synchronisers: three stages, stage 2 and 3 must agree for all pins but din
  logic [2:0] frame_s_reg, sclk_s_reg, din_s_reg, pwrdn_s_reg, ld_s_reg;
  logic       frame_reg, sclk_reg, pwrdn_reg, ld_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      frame_s_reg <= 3'h7;
      sclk_s_reg  <= 3'h0;
      din_s_reg   <= 3'h0;
      pwrdn_s_reg <= 3'h7;
      ld_s_reg    <= 3'h7;
    end else begin
      frame_s_reg <= {frame_s_reg[1:0], frame_n};
      sclk_s_reg  <= {sclk_s_reg[1:0], sclk};
      din_s_reg   <= {din_s_reg[1:0], din};
      pwrdn_s_reg <= {pwrdn_s_reg[1:0], hw_powerdown_n};
      ld_s_reg    <= {ld_s_reg[1:0], output_load_n};
    end
  end

  function automatic logic settle(input logic [2:0] s, input logic old);
    settle = (s[1] == s[2]) ? s[2] : old;
  endfunction

  always_ff @(posedge clock) begin
    if (srst) begin
      frame_reg <= 1'b1;
      sclk_reg  <= 1'b0;
      pwrdn_reg <= 1'b1;
      ld_reg    <= 1'b1;
    end else begin
      frame_reg <= settle(frame_s_reg, frame_reg);
      sclk_reg  <= settle(sclk_s_reg, sclk_reg);
      pwrdn_reg <= settle(pwrdn_s_reg, pwrdn_reg);
      ld_reg    <= settle(ld_s_reg, ld_reg);
    end
  end

  wire frame_next = settle(frame_s_reg, frame_reg);
  wire sclk_next  = settle(sclk_s_reg, sclk_reg);
  wire sclk_fall  = sclk_reg & ~sclk_next;
  // Data sampled at the same stage as the clock decision
  wire din_bit    = din_s_reg[2];

  // Serial shifter
  logic [WORD_BITS-1:0] shift_reg;
  logic [CNT_W-1:0]     count_reg;
  logic                 done_reg;

  wire active   = ~frame_reg & ~frame_next;
  wire take_bit = active & sclk_fall & (count_reg < FRAME_BITS);
  wire complete = take_bit & (count_reg == FRAME_BITS - 5'h01);

  always_ff @(posedge clock) begin
    if (srst | frame_reg) begin
      // Frame high clears the count, so a short frame loads nothing
      count_reg <= '0;
      shift_reg <= '0;
    end else if (take_bit) begin
      count_reg <= count_reg + 5'h01;
      shift_reg <= {shift_reg[WORD_BITS-2:0], din_bit};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) done_reg <= 1'b0;
    else      done_reg <= complete;
  end

  // Field decode of the completed word
  wire                 word_chan = shift_reg[POS_CHAN];
  wire                 word_gain = shift_reg[POS_GAIN];
  wire ddpd_mode_t     word_mode = ddpd_mode_t'({shift_reg[POS_PWRDN_HI], shift_reg[POS_PWRDN_LO]});
  wire [DATA_BITS-1:0] word_code = shift_reg[DATA_BITS-1:0];
  wire                 wr_a      = done_reg & ~word_chan;
  wire                 wr_b      = done_reg & word_chan;

  // Input registers, modes and DAC registers
  logic [DATA_BITS-1:0] in_a_reg, in_b_reg;
  logic                 gin_a_reg, gin_b_reg, fresh_a_reg, fresh_b_reg;
  ddpd_mode_t           mode_a_reg, mode_b_reg;

  wire load_a  = ~ld_reg & fresh_a_reg;
  wire load_b  = ~ld_reg & fresh_b_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      in_a_reg    <= CODE_RESET;
      in_b_reg    <= CODE_RESET;
      gin_a_reg   <= 1'b0;
      gin_b_reg   <= 1'b0;
      mode_a_reg  <= DDPD_MODE_NORMAL;
      mode_b_reg  <= DDPD_MODE_NORMAL;
      fresh_a_reg <= 1'b0;
      fresh_b_reg <= 1'b0;
    end else begin
      // Only the addressed channel changes; power-down never clears codes
      if (wr_a) begin
        in_a_reg   <= word_code;
        gin_a_reg  <= word_gain;
        mode_a_reg <= word_mode;
      end
      if (wr_b) begin
        in_b_reg   <= word_code;
        gin_b_reg  <= word_gain;
        mode_b_reg <= word_mode;
      end
      // New write wins over the transfer-clear in the same cycle
      fresh_a_reg <= wr_a | (fresh_a_reg & ~load_a);
      fresh_b_reg <= wr_b | (fresh_b_reg & ~load_b);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dac_code_a <= CODE_RESET;
      dac_code_b <= CODE_RESET;
      gain_a     <= 1'b0;
      gain_b     <= 1'b0;
    end else begin
      if (load_a) begin
        dac_code_a <= in_a_reg;
        gain_a     <= gin_a_reg;
      end
      if (load_b) begin
        dac_code_b <= in_b_reg;
        gain_b     <= gin_b_reg;
      end
    end
  end

  // Effective termination; pin overrides software modes
  wire ddpd_mode_t eff_a = ~pwrdn_reg ? DDPD_MODE_HIZ : mode_a_reg;
  wire ddpd_mode_t eff_b = ~pwrdn_reg ? DDPD_MODE_HIZ : mode_b_reg;
  wire             on_a  = (eff_a == DDPD_MODE_NORMAL);
  wire             on_b  = (eff_b == DDPD_MODE_NORMAL);
  wire [EXIT_W-1:0] exit_len = low_supply ? EXIT_W'(EXIT_CYC_LO) : EXIT_W'(EXIT_CYC_HI);

  logic [EXIT_W-1:0] wait_a_reg, wait_b_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      term_a     <= DDPD_MODE_NORMAL;
      term_b     <= DDPD_MODE_NORMAL;
      amp_on_a   <= 1'b1;
      amp_on_b   <= 1'b1;
      wait_a_reg <= '0;
      wait_b_reg <= '0;
    end else begin
      term_a   <= eff_a;
      term_b   <= eff_b;
      amp_on_a <= on_a;
      amp_on_b <= on_b;
      // Counter reloads on every powered-down cycle
      wait_a_reg <= !on_a ? exit_len : (wait_a_reg != '0 ? wait_a_reg - 1'b1 : '0);
      wait_b_reg <= !on_b ? exit_len : (wait_b_reg != '0 ? wait_b_reg - 1'b1 : '0);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      out_valid_a <= 1'b1;
      out_valid_b <= 1'b1;
    end else begin
      out_valid_a <= on_a & (wait_a_reg == '0);
      out_valid_b <= on_b & (wait_b_reg == '0);
    end
  end

  // Assertions
  chk_pin_forces_hiz: assert property (@(posedge clock) disable iff (srst)
    !pwrdn_reg |=> (term_a == DDPD_MODE_HIZ) && (term_b == DDPD_MODE_HIZ) && !amp_on_a && !amp_on_b)
    else $error("power-down pin did not force hi-z");
  chk_other_chan_kept: assert property (@(posedge clock) disable iff (srst)
    wr_a |=> mode_b_reg == $past(mode_b_reg))
    else $error("channel B mode changed on A write");
  chk_mode_latched: assert property (@(posedge clock) disable iff (srst)
    wr_b |=> mode_b_reg == ddpd_mode_t'({$past(shift_reg[POS_PWRDN_HI]), $past(shift_reg[POS_PWRDN_LO])}))
    else $error("mode not latched from bits 13,12");
  chk_code_held: assert property (@(posedge clock) disable iff (srst)
    !wr_a |=> in_a_reg == $past(in_a_reg))
    else $error("input register changed without write");
  chk_short_aborts: assert property (@(posedge clock) disable iff (srst)
    frame_reg |-> !done_reg ##1 !done_reg)
    else $error("load after early frame end");
  chk_count_limit: assert property (@(posedge clock) disable iff (srst)
    count_reg <= FRAME_BITS)
    else $error("bit count passed sixteen");
  chk_exit_delay: assert property (@(posedge clock) disable iff (srst)
    (!on_a ##1 on_a) |=> !out_valid_a [*8])
    else $error("output valid too soon after power-down exit");
  chk_term_decode: assert property (@(posedge clock) disable iff (srst)
    pwrdn_reg |=> (term_b == $past(mode_b_reg)) && (amp_on_b == ($past(mode_b_reg) == DDPD_MODE_NORMAL)))
    else $error("termination disagrees with latched mode");
  chk_chan_select: assert property (@(posedge clock) disable iff (srst)
    done_reg && !shift_reg[POS_CHAN] |=> in_a_reg == $past(shift_reg[DATA_BITS-1:0]))
    else $error("channel A not written when bit 15 clear");

endmodule // ddpd_top
